// >>> include/usml_pkg.sv
// constants, offsets and state types for the serial mode/status block
package usml_pkg;
    // timing: half a bit time at the line rate
    localparam int CLK_HZ   = 50_000_000;
    localparam int BAUD_HZ  = 115_200;
    localparam int HALF_DIV = CLK_HZ / (2 * BAUD_HZ);
    localparam logic [8:0] HALF_LAST = 9'(HALF_DIV - 1);
    localparam logic [8:0] QUART     = 9'(HALF_DIV / 2 - 1);
    // register byte offsets
    localparam logic [11:0] OFF_CMD   = 12'h000;
    localparam logic [11:0] OFF_MODE  = 12'h004;
    localparam logic [11:0] OFF_EVT   = 12'h008;
    localparam logic [11:0] OFF_MASK  = 12'h00c;
    localparam logic [11:0] OFF_STAT  = 12'h014;
    localparam logic [11:0] OFF_RHR   = 12'h018;
    localparam logic [11:0] OFF_THR   = 12'h01c;
    localparam logic [11:0] OFF_LINMR = 12'h054;
    localparam logic [11:0] OFF_LINIR = 12'h058;
    localparam logic [11:0] OFF_WPMR  = 12'h0e4;
    localparam logic [31:0] MODE_RST  = 32'h0000_0000;
    // command bits
    localparam int CMD_RSTRX = 2;
    localparam int CMD_RSTTX = 3;
    localparam int CMD_RXEN  = 4;
    localparam int CMD_RXDIS = 5;
    localparam int CMD_TXEN  = 6;
    localparam int CMD_TXDIS = 7;
    localparam int CMD_CLEAR_STATUS_CMD = 8;
    localparam int CMD_WKUP  = 21;
    // mode, status, lin and protect bits
    localparam int MODE_SINGLE_BIT_DELIMITER_SEL = 31;
    localparam int MODE_POL    = 30;
    localparam int MODE_MAN    = 29;
    localparam int ST_RX_CHAR_AVAILABLE = 0;
    localparam int ST_TX_HOLDING_FREE = 1;
    localparam int ST_OVERRUN_FLAG  = 5;
    localparam int ST_TXEMP = 9;
    localparam int LIN_CHKOFF = 3;
    localparam int LIN_CHECKSUM_VARIANT = 4;
    localparam int LIN_LSRC   = 5;
    localparam int LIN_FSOFF  = 6;
    localparam int LIN_WKTYP  = 7;
    localparam int LIN_DLC    = 16;
    localparam int WP_ON      = 0;
    localparam int EVT_W      = 5;
    // wakeup characters and gap
    localparam logic [7:0] WK_20 = 8'hf0;
    localparam logic [7:0] WK_13 = 8'h80;
    localparam logic [5:0] FSLOT_HALVES = 6'h14;
    localparam logic [4:0] SH_ONE  = 5'h02;
    localparam logic [4:0] SH_SYNC = 5'h06;
    localparam logic [4:0] SH_NRZ  = 5'h02;
    localparam logic [4:0] DATA_HALVES = 5'h10;
    localparam logic [4:0] STOP_HALVES = 5'h02;
    typedef enum logic [1:0] {USML_TX_IDLE = 2'b01, USML_TX_RUN = 2'b10} usml_tx_t;
    typedef enum logic [1:0] {USML_RX_IDLE = 2'b01, USML_RX_SAMP = 2'b10} usml_rx_t;
endpackage : usml_pkg

// >>> include/usml_line_if.sv
// link between register core and line engine
`timescale 1ns/1ns
interface usml_line_if;
    logic [7:0] tx_data;
    logic       tx_load;
    logic       tx_busy;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       man_en;
    logic       start_pol;
    logic       one_bit;
    logic       half_tick;
    modport core (output tx_data, tx_load, man_en, start_pol, one_bit,
                  input tx_busy, rx_data, rx_valid, half_tick);
    modport line (input tx_data, tx_load, man_en, start_pol, one_bit,
                  output tx_busy, rx_data, rx_valid, half_tick);
endinterface : usml_line_if

// >>> core/usml_line.sv
// bit-level line engine: nrz or biphase framing of one character
`timescale 1ns/1ns
module usml_line (
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // core side
    usml_line_if.line lif,
    // pins
    output logic      txd,
    input  wire logic rxd
);
    logic [8:0] hc_r;
    usml_pkg::usml_tx_t tst_r;
    usml_pkg::usml_rx_t rst_r;
    logic [7:0] td_r, rd_r;
    logic [4:0] th_r, tsh_r, rk_r, rskip_r;
    logic [8:0] rc_r;
    logic       r1_r, r2_r, r3_r, lvl, det;
    logic [4:0] j, rj;

    // free half-bit timer; framing is aligned to it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) hc_r <= 9'h000;
        else hc_r <= (hc_r == usml_pkg::HALF_LAST) ? 9'h000 : hc_r + 9'h001;
    end
    assign lif.half_tick = (hc_r == usml_pkg::HALF_LAST);

    // transmit sequencer, counted in half bits
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tst_r <= usml_pkg::USML_TX_IDLE;
            td_r  <= 8'h00;
            th_r  <= 5'h00;
            tsh_r <= usml_pkg::SH_NRZ;
        end else case (tst_r)
            usml_pkg::USML_TX_IDLE: if (lif.tx_load) begin
                td_r  <= lif.tx_data;
                th_r  <= 5'h00;
                tsh_r <= !lif.man_en ? usml_pkg::SH_NRZ :
                         lif.one_bit ? usml_pkg::SH_ONE : usml_pkg::SH_SYNC;
                tst_r <= usml_pkg::USML_TX_RUN;
            end
            usml_pkg::USML_TX_RUN: if (lif.half_tick) begin
                th_r <= th_r + 5'h01;
                if (th_r == tsh_r + usml_pkg::DATA_HALVES + usml_pkg::STOP_HALVES - 5'h01)
                    tst_r <= usml_pkg::USML_TX_IDLE;
            end
            default: tst_r <= usml_pkg::USML_TX_IDLE;
        endcase
    end
    assign lif.tx_busy = (tst_r == usml_pkg::USML_TX_RUN);

    // line level: biphase halves carry ~b then b; start shape per polarity
    always_comb begin
        j = th_r - tsh_r;
        if (tst_r != usml_pkg::USML_TX_RUN) lvl = 1'b1;
        else if (th_r < tsh_r)
            lvl = lif.man_en ? ((th_r < (tsh_r >> 1)) ? lif.start_pol : !lif.start_pol)
                             : 1'b0;
        else if (j < usml_pkg::DATA_HALVES)
            lvl = lif.man_en ? (j[0] ? td_r[j[3:1]] : !td_r[j[3:1]]) : td_r[j[3:1]];
        else lvl = 1'b1;
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) txd <= 1'b1;
        else txd <= lvl;
    end

    // receive pin synchroniser plus one history stage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) {r1_r, r2_r, r3_r} <= 3'b111;
        else {r1_r, r2_r, r3_r} <= {rxd, r1_r, r2_r};
    end
    // biphase start only on the edge of the configured direction
    assign det = lif.man_en ? (r3_r == lif.start_pol) && (r2_r != lif.start_pol)
                            : (r3_r && !r2_r);
    assign rj = rk_r - rskip_r;

    // receive sampler: one sample per half bit, data taken on second half
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_r <= usml_pkg::USML_RX_IDLE;
            rc_r <= 9'h000;
            rk_r <= 5'h00;
            rskip_r <= 5'h02;
            rd_r <= 8'h00;
            lif.rx_valid <= 1'b0;
            lif.rx_data <= 8'h00;
        end else begin
            lif.rx_valid <= 1'b0;
            case (rst_r)
                usml_pkg::USML_RX_IDLE: if (det) begin
                    rc_r <= usml_pkg::QUART;
                    rk_r <= 5'h00;
                    rskip_r <= !lif.man_en ? 5'h02 : lif.one_bit ? 5'h01 : 5'h03;
                    rst_r <= usml_pkg::USML_RX_SAMP;
                end
                usml_pkg::USML_RX_SAMP: if (rc_r != 9'h000) rc_r <= rc_r - 9'h001;
                else begin
                    rc_r <= usml_pkg::HALF_LAST;
                    rk_r <= rk_r + 5'h01;
                    if (rk_r >= rskip_r && rj[0]) rd_r <= {r2_r, rd_r[7:1]};
                    if (rk_r >= rskip_r && rj == 5'h0f) begin
                        lif.rx_data <= {r2_r, rd_r[7:1]};
                        lif.rx_valid <= 1'b1;
                        rst_r <= usml_pkg::USML_RX_IDLE;
                    end
                end
                default: rst_r <= usml_pkg::USML_RX_IDLE;
            endcase
        end
    end
endmodule : usml_line

// >>> core/usml_top.sv
// serial mode, status flags and lin options behind an apb slave
`timescale 1ns/1ns
// How it works
// - mode bit 31 picks one-bit start delimiter, else sync pattern
// - mode bit 30 sets biphase start edge: clear rising, set falling
// - mode bit 29 turns biphase encode and decode on together
// - tx empty is one only with holding and shift both empty
// - overrun status bit 5 latches until clear-status command
// - tx ready drops on holding write, zero while tx disabled
// - rx ready set by full character, cleared by read, zero when disabled
// - characters arriving while disabled raise rx ready on re-enable
// - wakeup command sends lin 2.0 or 1.3 wakeup per type bit
// - lin bit 6 clear keeps frame slot gap, set drops it
// - lin bit 5 picks length from code field or identifier bits
// - checksum type clear is enhanced, set is classic
// - checksum sent and checked unless checksum processing is off
// - mode register ignores writes while write protect is on
module usml_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial line
    output logic             txd,
    input  wire logic        rxd,
    // interrupt
    output logic             irq
);
    usml_line_if lif();

    logic [31:0] mode_r, linmr_r;
    logic [7:0]  linid_r, thr_r, rhr_r, sum_r;
    logic [8:0]  cnt_r;
    logic [5:0]  gap_r;
    localparam int EVT_W_L = usml_pkg::EVT_W;
    logic [EVT_W_L-1:0] evt_r, mask_r, evt_set;
    logic wp_r, tx_en_r, rx_en_r, thr_full_r, rx_char_available_r, hid_r, overrun_flag_r;
    logic wk_pend_r, chk_pend_r, frame_r, busy_q_r;
    logic wr, rd, setup, mapped, ld_go, ld_wk, ld_chk, ld_thr;
    logic rd_rhr, wr_cmd, tx_byte, rx_byte, chk_bad, fs_start;
    logic [31:0] stat, rdv;
    logic [8:0]  rlen;

    // address match, used by every decoder below
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // checksum add with carry wrap
    function automatic logic [7:0] chk_add(input logic [7:0] s, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        chk_add = t[7:0] + {7'h00, t[8]};
    endfunction : chk_add

    // response length from code field or identifier bits 5 and 6
    function automatic logic [8:0] resp_len(input logic [31:0] lm, input logic [7:0] id);
        logic [1:0] ib;
        ib = {id[6], id[5]};
        if (lm[usml_pkg::LIN_LSRC])
            resp_len = (ib == 2'b11) ? 9'h008 : (ib == 2'b10) ? 9'h004 : 9'h002;
        else
            resp_len = {1'b0, lm[usml_pkg::LIN_DLC +: 8]} + 9'h001;
    endfunction : resp_len

    // apb phases: answer is always ready in the access cycle
    assign setup   = psel && !penable;
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign mapped  = hit(paddr, usml_pkg::OFF_CMD)   || hit(paddr, usml_pkg::OFF_MODE) ||
                     hit(paddr, usml_pkg::OFF_EVT)   || hit(paddr, usml_pkg::OFF_MASK) ||
                     hit(paddr, usml_pkg::OFF_STAT)  || hit(paddr, usml_pkg::OFF_RHR)  ||
                     hit(paddr, usml_pkg::OFF_THR)   || hit(paddr, usml_pkg::OFF_LINMR) ||
                     hit(paddr, usml_pkg::OFF_LINIR) || hit(paddr, usml_pkg::OFF_WPMR);
    assign pslverr = psel && penable && !mapped;
    assign rd_rhr  = rd && hit(paddr, usml_pkg::OFF_RHR);
    assign wr_cmd  = wr && hit(paddr, usml_pkg::OFF_CMD);
    assign rlen    = resp_len(linmr_r, linid_r);

    // status word; ready and empty flags gated by enables, overrun is not
    always_comb begin
        stat = 32'h0000_0000;
        stat[usml_pkg::ST_RX_CHAR_AVAILABLE] = rx_en_r && rx_char_available_r;
        stat[usml_pkg::ST_TX_HOLDING_FREE] = tx_en_r && !thr_full_r;
        stat[usml_pkg::ST_OVERRUN_FLAG]  = overrun_flag_r;
        stat[usml_pkg::ST_TXEMP] = tx_en_r && !thr_full_r && !lif.tx_busy;
    end

    // read mux; write-only and unmapped words read zero
    always_comb begin
        rdv = 32'h0000_0000;
        if (hit(paddr, usml_pkg::OFF_MODE))  rdv = mode_r;
        if (hit(paddr, usml_pkg::OFF_EVT))   rdv = {27'h0, evt_r};
        if (hit(paddr, usml_pkg::OFF_MASK))  rdv = {27'h0, mask_r};
        if (hit(paddr, usml_pkg::OFF_STAT))  rdv = stat;
        if (hit(paddr, usml_pkg::OFF_RHR))   rdv = {24'h0, rhr_r};
        if (hit(paddr, usml_pkg::OFF_LINMR)) rdv = linmr_r;
        if (hit(paddr, usml_pkg::OFF_LINIR)) rdv = {24'h0, linid_r};
        if (hit(paddr, usml_pkg::OFF_WPMR))  rdv = {31'h0, wp_r};
    end

    // read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) prdata <= 32'h0000_0000;
        else if (setup && !pwrite) prdata <= rdv;
    end

    // configuration registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_r  <= usml_pkg::MODE_RST;
            linmr_r <= 32'h0000_0000;
            linid_r <= 8'h00;
            wp_r    <= 1'b0;
            mask_r  <= '0;
        end else if (wr) begin
            if (hit(paddr, usml_pkg::OFF_MODE) && !wp_r) mode_r <= pwdata;
            if (hit(paddr, usml_pkg::OFF_LINMR)) linmr_r <= pwdata;
            if (hit(paddr, usml_pkg::OFF_LINIR)) linid_r <= pwdata[7:0];
            if (hit(paddr, usml_pkg::OFF_WPMR))  wp_r <= pwdata[usml_pkg::WP_ON];
            if (hit(paddr, usml_pkg::OFF_MASK))  mask_r <= pwdata[EVT_W_L-1:0];
        end
    end

    // line engine configuration
    assign lif.one_bit   = mode_r[usml_pkg::MODE_SINGLE_BIT_DELIMITER_SEL];
    assign lif.start_pol = mode_r[usml_pkg::MODE_POL];
    assign lif.man_en    = mode_r[usml_pkg::MODE_MAN];

    // load priority: wakeup, then checksum, then holding register
    assign ld_go  = tx_en_r && !lif.tx_busy && (gap_r == 6'h00) &&
                    (wk_pend_r || chk_pend_r || thr_full_r);
    assign ld_wk  = ld_go && wk_pend_r;
    assign ld_chk = ld_go && !wk_pend_r && chk_pend_r;
    assign ld_thr = ld_go && !wk_pend_r && !chk_pend_r;
    assign lif.tx_load = ld_go;
    always_comb begin
        if (ld_wk)
            lif.tx_data = linmr_r[usml_pkg::LIN_WKTYP] ? usml_pkg::WK_13
                                                       : usml_pkg::WK_20;
        else if (ld_chk) lif.tx_data = ~sum_r;
        else lif.tx_data = thr_r;
    end

    // enables from the command register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_en_r <= 1'b0;
            rx_en_r <= 1'b0;
        end else if (wr_cmd) begin
            if (pwdata[usml_pkg::CMD_TXDIS]) tx_en_r <= 1'b0;
            else if (pwdata[usml_pkg::CMD_TXEN]) tx_en_r <= 1'b1;
            if (pwdata[usml_pkg::CMD_RXDIS]) rx_en_r <= 1'b0;
            else if (pwdata[usml_pkg::CMD_RXEN]) rx_en_r <= 1'b1;
        end
    end

    // transmit holding register; a new write wins over the load
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            thr_r <= 8'h00;
            thr_full_r <= 1'b0;
        end else if (wr && hit(paddr, usml_pkg::OFF_THR)) begin
            thr_r <= pwdata[7:0];
            thr_full_r <= 1'b1;
        end else if (ld_thr || (wr_cmd && pwdata[usml_pkg::CMD_RSTTX])) begin
            thr_full_r <= 1'b0;
        end
    end

    // wakeup request waits for an idle transmitter
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) wk_pend_r <= 1'b0;
        else if (wr_cmd && pwdata[usml_pkg::CMD_WKUP]) wk_pend_r <= 1'b1;
        else if (ld_wk || (wr_cmd && pwdata[usml_pkg::CMD_RSTTX])) wk_pend_r <= 1'b0;
    end

    // receive holding: bytes caught while disabled are kept, not flagged
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rhr_r <= 8'h00;
            rx_char_available_r <= 1'b0;
            hid_r <= 1'b0;
        end else if (lif.rx_valid) begin
            rhr_r <= lif.rx_data;
            if (rx_en_r) rx_char_available_r <= 1'b1;
            else hid_r <= 1'b1;
        end else if (wr_cmd && pwdata[usml_pkg::CMD_RSTRX]) begin
            rx_char_available_r <= 1'b0;
            hid_r <= 1'b0;
        end else if (rd_rhr) begin
            rx_char_available_r <= 1'b0;
        end else if (wr_cmd && pwdata[usml_pkg::CMD_RXEN] && hid_r) begin
            rx_char_available_r <= 1'b1;
            hid_r <= 1'b0;
        end
    end

    // overrun: set wins over the clear command
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) overrun_flag_r <= 1'b0;
        else if (lif.rx_valid && rx_en_r && rx_char_available_r && !rd_rhr) overrun_flag_r <= 1'b1;
        else if (wr_cmd && pwdata[usml_pkg::CMD_CLEAR_STATUS_CMD]) overrun_flag_r <= 1'b0;
    end

    // lin response tracking, checksum accumulate, send and check
    assign tx_byte = ld_thr && frame_r;
    assign rx_byte = lif.rx_valid && frame_r;
    assign chk_bad = rx_byte && (cnt_r == rlen) && (lif.rx_data != ~sum_r);
    assign fs_start = ld_chk || (rx_byte && cnt_r == rlen) ||
                      ((tx_byte || rx_byte) && linmr_r[usml_pkg::LIN_CHKOFF] &&
                       cnt_r + 9'h001 == rlen);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            frame_r <= 1'b0;
            sum_r <= 8'h00;
            cnt_r <= 9'h000;
            chk_pend_r <= 1'b0;
        end else if (wr && hit(paddr, usml_pkg::OFF_LINIR)) begin
            frame_r <= 1'b1;
            cnt_r <= 9'h000;
            chk_pend_r <= 1'b0;
            // enhanced sum covers the identifier, classic does not
            sum_r <= linmr_r[usml_pkg::LIN_CHECKSUM_VARIANT] ? 8'h00 : pwdata[7:0];
        end else if (ld_chk) begin
            chk_pend_r <= 1'b0;
        end else if (tx_byte || (rx_byte && cnt_r != rlen)) begin
            sum_r <= chk_add(sum_r, tx_byte ? thr_r : lif.rx_data);
            cnt_r <= cnt_r + 9'h001;
            if (cnt_r + 9'h001 == rlen) begin
                if (linmr_r[usml_pkg::LIN_CHKOFF]) frame_r <= 1'b0;
                else if (tx_byte) begin
                    chk_pend_r <= 1'b1;
                    frame_r <= 1'b0;
                end
            end
        end else if (rx_byte) begin
            frame_r <= 1'b0;
        end
    end

    // frame slot gap after a response holds off the next load
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) gap_r <= 6'h00;
        else if (fs_start)
            gap_r <= linmr_r[usml_pkg::LIN_FSOFF] ? 6'h00 : usml_pkg::FSLOT_HALVES;
        else if (lif.half_tick && gap_r != 6'h00) gap_r <= gap_r - 6'h01;
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) busy_q_r <= 1'b0;
        else busy_q_r <= lif.tx_busy;
    end
    assign evt_set = {ld_wk, chk_bad, lif.rx_valid && rx_en_r && rx_char_available_r && !rd_rhr,
                      busy_q_r && !lif.tx_busy, lif.rx_valid && rx_en_r};
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) evt_r <= '0;
        else if (wr && hit(paddr, usml_pkg::OFF_EVT))
            evt_r <= (evt_r & ~pwdata[EVT_W_L-1:0]) | evt_set;
        else evt_r <= evt_r | evt_set;
    end
    assign irq = |(evt_r & mask_r);

    // line engine
    usml_line u_line (
        .mclk   (mclk),
        .resetn (resetn),
        .lif    (lif.line),
        .txd    (txd),
        .rxd    (rxd)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_mode_wp_hold: assert property (wr && hit(paddr, usml_pkg::OFF_MODE) && wp_r
        |=> $stable(mode_r)) else $error("mode written while protected");
    a_mode_take: assert property (wr && hit(paddr, usml_pkg::OFF_MODE) && !wp_r
        |=> mode_r == $past(pwdata)) else $error("mode write lost");
    a_tx_holding_free_clr: assert property (wr && hit(paddr, usml_pkg::OFF_THR)
        |=> !stat[usml_pkg::ST_TX_HOLDING_FREE]) else $error("tx ready after holding write");
    a_txempty_both: assert property (stat[usml_pkg::ST_TXEMP]
        |-> stat[usml_pkg::ST_TX_HOLDING_FREE] && !lif.tx_busy) else $error("tx empty wrong");
    a_overrun_flag_sticky: assert property (overrun_flag_r && !(wr_cmd && pwdata[usml_pkg::CMD_CLEAR_STATUS_CMD])
        |=> overrun_flag_r) else $error("overrun lost");
    a_overrun_flag_set: assert property (lif.rx_valid && rx_en_r && rx_char_available_r && !rd_rhr
        |=> overrun_flag_r && stat[usml_pkg::ST_OVERRUN_FLAG]) else $error("overrun missed");
    a_rx_char_available_off: assert property (!rx_en_r |-> !stat[usml_pkg::ST_RX_CHAR_AVAILABLE])
        else $error("rx ready while disabled");
    a_rx_char_available_read: assert property (rd_rhr && !lif.rx_valid |=> !rx_char_available_r)
        else $error("rx ready kept after read");
    a_rx_char_available_wake: assert property (hid_r && !lif.rx_valid && !rd_rhr && wr_cmd &&
        pwdata[usml_pkg::CMD_RXEN] && !pwdata[usml_pkg::CMD_RXDIS] &&
        !pwdata[usml_pkg::CMD_RSTRX] |=> stat[usml_pkg::ST_RX_CHAR_AVAILABLE])
        else $error("held character not flagged");
    a_wkup_char: assert property (ld_wk |-> lif.tx_data ==
        (linmr_r[usml_pkg::LIN_WKTYP] ? usml_pkg::WK_13 : usml_pkg::WK_20))
        else $error("wrong wakeup character");
    a_chk_send: assert property (tx_byte && !linmr_r[usml_pkg::LIN_CHKOFF] &&
        cnt_r + 9'h001 == rlen |=> chk_pend_r ##0 !frame_r) else $error("checksum not queued");

    c_wakeup: cover property (ld_wk);
    c_rx_char: cover property (lif.rx_valid && rx_en_r);
    c_chk_err: cover property (chk_bad);
    c_overrun: cover property (!overrun_flag_r ##1 overrun_flag_r);
endmodule : usml_top

// >>> verification/usml_remote.sv
// remote serial node: nrz sender and receiver on the line
`timescale 1ns/1ns
module usml_remote (
    // clock
    input  wire logic mclk,
    // line
    input  wire logic txd,
    output logic      rxd
);
    localparam int BITC = 2 * usml_pkg::HALF_DIV; // one bit cell in mclk cycles
    logic [7:0] got;
    int         got_n = 0;
    initial rxd = 1'b1;
    // one character lsb first, line idles high after stop
    task send(input logic [7:0] b);
        rxd <= 1'b0;
        repeat (BITC) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            rxd <= b[i];
            repeat (BITC) @(posedge mclk);
        end
        rxd <= 1'b1;
        repeat (BITC) @(posedge mclk);
    endtask : send
    // mid-cell sampling tolerates the engine's half-bit launch skew
    always @(negedge txd) begin
        repeat (BITC + BITC / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            got[i] = txd;
            repeat (BITC) @(posedge mclk);
        end
        got_n++;
    end
endmodule : usml_remote

// >>> verification/testbench.sv
// bench: register, line and interrupt checks for the serial mode block
`timescale 1ns/1ns
module testbench;
    logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, txd, rxd, irq, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          errors = 0;
    int          checks_done = 0;
    usml_top uut (.mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txd(txd), .rxd(rxd), .irq(irq));
    usml_remote peer (.mclk(mclk), .txd(txd), .rxd(rxd));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task test_done;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        se = pslverr;
        {psel, penable} <= 2'b00;
        if (n == 50) begin
            errors++;
            test_done();
        end
    endtask : apb
    // bounded poll of one status bit
    task poll(input int b, input logic v);
        for (int i = 0; i < 4000; i++) begin
            apb(1'b0, usml_pkg::OFF_STAT, 32'h0);
            if (rd[b] === v) return;
        end
        errors++;
        test_done();
    endtask : poll
    task t_mode;
        apb(1'b0, usml_pkg::OFF_MODE, 32'h0); chk(rd, usml_pkg::MODE_RST);
        apb(1'b0, usml_pkg::OFF_STAT, 32'h0); chk(rd, 32'h0);
        apb(1'b1, usml_pkg::OFF_MODE, 32'he000_0000);
        apb(1'b0, usml_pkg::OFF_MODE, 32'h0); chk(rd, 32'he000_0000);
        apb(1'b1, usml_pkg::OFF_WPMR, 32'h1);
        apb(1'b1, usml_pkg::OFF_MODE, 32'h0);
        apb(1'b0, usml_pkg::OFF_MODE, 32'h0); chk(rd, 32'he000_0000);
        apb(1'b1, usml_pkg::OFF_WPMR, 32'h0);
        apb(1'b1, usml_pkg::OFF_MODE, 32'h0);
        apb(1'b0, usml_pkg::OFF_MODE, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 12'h0f0, 32'h0); chk({31'h0, se}, 32'h1);
    endtask : t_mode
    task t_tx(input logic [31:0] cmd, input logic [7:0] e, input int n);
        int i;
        apb(1'b1, usml_pkg::OFF_CMD, cmd);
        for (i = 0; i < 20000 && peer.got_n < n; i++) @(posedge mclk);
        if (i == 20000) begin
            errors++;
            test_done();
        end
        chk({24'h0, peer.got}, {24'h0, e});
        poll(usml_pkg::ST_TXEMP, 1'b1);
        chk(rd & 32'h202, 32'h202);
    endtask : t_tx
    task t_rx;
        apb(1'b1, usml_pkg::OFF_MASK, 32'h4);
        apb(1'b1, usml_pkg::OFF_CMD, 32'h10);
        peer.send(8'h3c);
        poll(usml_pkg::ST_RX_CHAR_AVAILABLE, 1'b1);
        apb(1'b0, usml_pkg::OFF_RHR, 32'h0); chk(rd & 32'hff, 32'h3c);
        apb(1'b0, usml_pkg::OFF_STAT, 32'h0); chk(rd & 32'h1, 32'h0);
        peer.send(8'h11);
        peer.send(8'h22);
        poll(usml_pkg::ST_OVERRUN_FLAG, 1'b1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, usml_pkg::OFF_CMD, 32'h100);
        apb(1'b0, usml_pkg::OFF_STAT, 32'h0); chk(rd & 32'h20, 32'h0);
        apb(1'b1, usml_pkg::OFF_EVT, 32'h1f);
        // the clear lands at the access edge, so look one edge later
        @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_rx
    // characters caught while disabled show up on re-enable
    task t_hold;
        apb(1'b0, usml_pkg::OFF_RHR, 32'h0); chk(rd & 32'hff, 32'h22);
        apb(1'b1, usml_pkg::OFF_CMD, 32'h20);
        peer.send(8'h5a);
        apb(1'b0, usml_pkg::OFF_STAT, 32'h0); chk(rd & 32'h1, 32'h0);
        apb(1'b1, usml_pkg::OFF_CMD, 32'h10);
        apb(1'b0, usml_pkg::OFF_STAT, 32'h0); chk(rd & 32'h1, 32'h1);
        apb(1'b0, usml_pkg::OFF_RHR, 32'h0); chk(rd & 32'hff, 32'h5a);
    endtask : t_hold
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        t_mode();
        apb(1'b1, usml_pkg::OFF_CMD, 32'h40);
        apb(1'b1, usml_pkg::OFF_THR, 32'ha5);
        apb(1'b0, usml_pkg::OFF_STAT, 32'h0); chk(rd & 32'h200, 32'h0);
        t_tx(32'h0, 8'ha5, 1);
        t_tx(32'h20_0000, usml_pkg::WK_20, 2);
        apb(1'b1, usml_pkg::OFF_LINMR, 32'h80);
        t_tx(32'h20_0000, usml_pkg::WK_13, 3);
        t_rx();
        t_hold();
        test_done();
    end
endmodule : testbench
